/* File: logic/uft_defs.vh */
`ifndef UFT_DEFS_VH
`define UFT_DEFS_VH

// register word indices inside one channel window, byte address = base + 4 * index
`define UFT_IDX_CTRL      3'h0
`define UFT_IDX_TXDATA    3'h1
`define UFT_IDX_RXDATA    3'h2
`define UFT_IDX_STATUS    3'h3
`define UFT_IDX_ISTAT     3'h4
`define UFT_IDX_IMASK     3'h5
`define UFT_IDX_LAST      3'h5

// fifo_control field positions
`define UFT_CTRL_EN       0
`define UFT_CTRL_RXCLR    1
`define UFT_CTRL_TXCLR    2
`define UFT_CTRL_DMA      3
`define UFT_CTRL_THR_LO   6
`define UFT_CTRL_THR_HI   7

// reset values
`define UFT_CTRL_RST      8'h00
`define UFT_IMASK_RST     4'h0
`define UFT_ISTAT_RST     4'h0

// receive threshold levels in characters
`define UFT_THR_00        8'h01
`define UFT_THR_01        8'h04
`define UFT_THR_10        8'h08
`define UFT_THR_11        8'h0e

// interrupt status bit positions
`define UFT_INT_TXEMPTY   0
`define UFT_INT_RXTHR     1
`define UFT_INT_RXTO      2
`define UFT_INT_RXOVR     3

// status register field positions
`define UFT_STAT_TXCNT    0
`define UFT_STAT_RXCNT    8
`define UFT_STAT_FLAGS    16

`endif

/* File: logic/uft_fifo.v */
`timescale 1ns/1ps
module uft_fifo #(
  parameter DW    = 8,
  parameter DEPTH = 16,
  parameter CW    = 5
) (
  input  wire          clk_i,
  input  wire          rst_n_i,
  input  wire          clr_i,
  input  wire          push_i,
  input  wire          pop_i,
  input  wire [DW-1:0] din_i,
  input  wire [CW-1:0] cap_i,
  output wire [DW-1:0] dout_o,
  output wire [CW-1:0] count_o,
  output wire          full_o,
  output wire          empty_o
);

  localparam AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam [AW-1:0] PTR_ONE = 1;
  localparam [CW-1:0] CNT_ONE = 1;

  reg [DW-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_r;
  reg [AW-1:0] rd_ptr_r;
  reg [CW-1:0] count_r;

  wire do_push;
  wire do_pop;

  // cap_i shrinks the fifo to a single holding register when fifos are off
  assign full_o  = (count_r >= cap_i);
  assign empty_o = (count_r == {CW{1'b0}});
  assign do_push = push_i & ~full_o;
  assign do_pop  = pop_i & ~empty_o;
  assign dout_o  = mem_r[rd_ptr_r];
  assign count_o = count_r;

  always @(posedge clk_i) begin
    if (do_push & ~clr_i) begin
      mem_r[wr_ptr_r] <= din_i;
    end
  end

  // depth must be a power of two so the pointers wrap on their own
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r  <= {CW{1'b0}};
    end else if (clr_i) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r  <= {CW{1'b0}};
    end else begin
      if (do_push) begin
        wr_ptr_r <= wr_ptr_r + PTR_ONE;
      end
      if (do_pop) begin
        rd_ptr_r <= rd_ptr_r + PTR_ONE;
      end
      if (do_push & ~do_pop) begin
        count_r <= count_r + CNT_ONE;
      end else if (do_pop & ~do_push) begin
        count_r <= count_r - CNT_ONE;
      end
    end
  end

endmodule

/* File: logic/uft_top.v */
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/1ps
`include "uft_defs.vh"

// Summary of operation
// R1 - mode 0 or fifos off: tx request low while tx fifo or holding register empty
// R2 - mode 0: tx request returns high once a character is written
// R3 - mode 0 or fifos off: rx request low once one character is held
// R4 - mode 0: rx request returns high when no received characters remain
// R5 - mode 1: tx request low while any tx location free, high only when full
// R6 - mode 1: rx request low on threshold or time-out, high once rx fifo empty
// R7 - mode 1: transmit interrupt raised when tx fifo becomes empty
// R8 - mode 1: receive interrupt at threshold; receive fifo keeps filling until full
// R9 - bits 7-6 select threshold; interrupt when count equals it; reset zero
// R10 - control bits 5-4 unused, held and read as zero
// R11 - control bit 3 selects dma mode 0 or mode 1
// R12 - writing bit 2 clears tx fifo and counters; bit self-clears
// R13 - bit 0 enables fifos; other bits ignored unless written with bit 0 set
// R14 - writing bit 1 clears rx fifo and counters; bit self-clears
// R15 - threshold codes 00,01,10,11 give 1,4,8,14 characters
// R16 - separate registered tx and rx request outputs per channel, high after reset
module uft_top #(
  parameter DW    = 8,
  parameter DEPTH = 16
) (
  input  wire            CORE_CLK_I,
  input  wire            RST_N_I,
  input  wire            PSEL_I,
  input  wire            PENABLE_I,
  input  wire            PWRITE_I,
  input  wire [7:0]      PADDR_I,
  input  wire [31:0]     PWDATA_I,
  output wire [31:0]     PRDATA_O,
  output wire            PREADY_O,
  output wire            PSLVERR_O,
  output wire            IRQ_O,
  input  wire [1:0]      TX_LOAD_I,
  output wire [2*DW-1:0] TX_DATA_O,
  output wire [1:0]      TX_AVAIL_O,
  input  wire [1:0]      RX_PUSH_I,
  input  wire [2*DW-1:0] RX_DATA_I,
  input  wire [1:0]      RX_TIMEOUT_I,
  output wire [1:0]      TX_REQUEST_N_O,
  output wire [1:0]      RX_REQUEST_N_O
);

  localparam NCH = 2;
  localparam CW  = $clog2(DEPTH) + 1;
  localparam [CW-1:0] CAP_FIFO = DEPTH;
  localparam [CW-1:0] CAP_HOLD = 1;

  function [7:0] thr_level;
    input [1:0] sel;
    begin
      case (sel)
        2'b00:   thr_level = `UFT_THR_00;
        2'b01:   thr_level = `UFT_THR_01;
        2'b10:   thr_level = `UFT_THR_10;
        2'b11:   thr_level = `UFT_THR_11;
        default: thr_level = `UFT_THR_00;
      endcase
    end
  endfunction

  function [7:0] ext8;
    input [CW-1:0] v;
    begin
      ext8 = {{(8-CW){1'b0}}, v};
    end
  endfunction

  reg  [8*NCH-1:0]  ctrl_r;
  reg  [4*NCH-1:0]  istat_r;
  reg  [4*NCH-1:0]  imask_r;
  reg  [NCH-1:0]    tx_req_n_r;
  reg  [NCH-1:0]    rx_req_n_r;
  reg  [NCH-1:0]    tx_empty_d_r;
  reg  [NCH-1:0]    rx_hit_d_r;
  reg  [NCH-1:0]    tx_avail_r;
  reg  [NCH*DW-1:0] tx_data_r;
  reg  [31:0]       prdata_r;
  reg               pready_r;
  reg               pslverr_r;
  reg               irq_r;

  wire [NCH*CW-1:0] tx_cnt_w;
  wire [NCH*CW-1:0] rx_cnt_w;
  wire [NCH*DW-1:0] tx_head_w;
  wire [NCH*DW-1:0] rx_head_w;
  wire [NCH-1:0]    tx_full_w;
  wire [NCH-1:0]    tx_empty_w;
  wire [NCH-1:0]    rx_full_w;
  wire [NCH-1:0]    rx_empty_w;

  reg  [NCH-1:0]    tx_push;
  reg  [NCH-1:0]    tx_pop;
  reg  [NCH-1:0]    tx_clr;
  reg  [NCH-1:0]    rx_push;
  reg  [NCH-1:0]    rx_pop;
  reg  [NCH-1:0]    rx_clr;
  reg  [NCH-1:0]    fifo_en;
  reg  [NCH-1:0]    mode1;
  reg  [NCH-1:0]    rx_hit;
  reg  [NCH*CW-1:0] cap;
  reg  [8*NCH-1:0]  ctrl_nxt;
  reg  [4*NCH-1:0]  istat_nxt;
  reg  [4*NCH-1:0]  imask_nxt;
  reg  [31:0]       rd_val;

  wire       acc     = PSEL_I & PENABLE_I;
  wire       done    = acc & pready_r;
  wire [2:0] idx     = PADDR_I[4:2];
  wire       sel_ch  = PADDR_I[5];
  wire       hit     = (PADDR_I[7:6] == 2'b00) & (PADDR_I[1:0] == 2'b00) &
                       (idx <= `UFT_IDX_LAST);
  wire       wr      = done & PWRITE_I & hit;
  wire       rd      = done & ~PWRITE_I & hit;

  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_ch
      uft_fifo #(
        .DW    (DW),
        .DEPTH (DEPTH),
        .CW    (CW)
      ) u_tx_fifo (
        .clk_i   (CORE_CLK_I),
        .rst_n_i (RST_N_I),
        .clr_i   (tx_clr[g]),
        .push_i  (tx_push[g]),
        .pop_i   (tx_pop[g]),
        .din_i   (PWDATA_I[DW-1:0]),
        .cap_i   (cap[g*CW +: CW]),
        .dout_o  (tx_head_w[g*DW +: DW]),
        .count_o (tx_cnt_w[g*CW +: CW]),
        .full_o  (tx_full_w[g]),
        .empty_o (tx_empty_w[g])
      );
      uft_fifo #(
        .DW    (DW),
        .DEPTH (DEPTH),
        .CW    (CW)
      ) u_rx_fifo (
        .clk_i   (CORE_CLK_I),
        .rst_n_i (RST_N_I),
        .clr_i   (rx_clr[g]),
        .push_i  (rx_push[g]),
        .pop_i   (rx_pop[g]),
        .din_i   (RX_DATA_I[g*DW +: DW]),
        .cap_i   (cap[g*CW +: CW]),
        .dout_o  (rx_head_w[g*DW +: DW]),
        .count_o (rx_cnt_w[g*CW +: CW]),
        .full_o  (rx_full_w[g]),
        .empty_o (rx_empty_w[g])
      );
    end
  endgenerate

  integer i;
  always @* begin
    ctrl_nxt  = ctrl_r;
    istat_nxt = istat_r;
    imask_nxt = imask_r;
    for (i = 0; i < NCH; i = i + 1) begin
      fifo_en[i]      = ctrl_r[i*8 + `UFT_CTRL_EN];
      mode1[i]        = fifo_en[i] & ctrl_r[i*8 + `UFT_CTRL_DMA]; // R11
      cap[i*CW +: CW] = fifo_en[i] ? CAP_FIFO : CAP_HOLD;
      rx_hit[i]       = fifo_en[i] &
                        (ext8(rx_cnt_w[i*CW +: CW]) >=
                         thr_level(ctrl_r[i*8+`UFT_CTRL_THR_LO +: 2])); // R9 R15
      tx_push[i] = wr & (sel_ch == i) & (idx == `UFT_IDX_TXDATA);
      tx_pop[i]  = TX_LOAD_I[i];
      rx_push[i] = RX_PUSH_I[i] & ~rx_full_w[i]; // R8
      rx_pop[i]  = rd & (sel_ch == i) & (idx == `UFT_IDX_RXDATA);
      tx_clr[i]  = 1'b0;
      rx_clr[i]  = 1'b0;
      if (wr & (sel_ch == i) & (idx == `UFT_IDX_CTRL)) begin
        if (PWDATA_I[`UFT_CTRL_EN]) begin // R13
          ctrl_nxt[i*8 +: 8] = {PWDATA_I[7:6], 2'b00, PWDATA_I[3], 2'b00, 1'b1}; // R10
          tx_clr[i] = PWDATA_I[`UFT_CTRL_TXCLR] | ~fifo_en[i]; // R12
          rx_clr[i] = PWDATA_I[`UFT_CTRL_RXCLR] | ~fifo_en[i]; // R14
        end else begin
          ctrl_nxt[i*8 + `UFT_CTRL_EN] = 1'b0; // R13
          tx_clr[i] = fifo_en[i];
          rx_clr[i] = fifo_en[i];
        end
      end
      if (wr & (sel_ch == i) & (idx == `UFT_IDX_ISTAT)) begin
        istat_nxt[i*4 +: 4] = istat_r[i*4 +: 4] & ~PWDATA_I[3:0];
      end
      if (wr & (sel_ch == i) & (idx == `UFT_IDX_IMASK)) begin
        imask_nxt[i*4 +: 4] = PWDATA_I[3:0];
      end
      // events are ored in last so a set wins over a same-cycle clear
      if (tx_empty_w[i] & ~tx_empty_d_r[i]) begin
        istat_nxt[i*4 + `UFT_INT_TXEMPTY] = 1'b1; // R7
      end
      if (rx_hit[i] & ~rx_hit_d_r[i]) begin
        istat_nxt[i*4 + `UFT_INT_RXTHR] = 1'b1; // R8 R9
      end
      if (RX_TIMEOUT_I[i] & fifo_en[i]) begin
        istat_nxt[i*4 + `UFT_INT_RXTO] = 1'b1;
      end
      if (RX_PUSH_I[i] & rx_full_w[i]) begin
        istat_nxt[i*4 + `UFT_INT_RXOVR] = 1'b1;
      end
    end
  end

  always @* begin
    rd_val = 32'h0000_0000;
    case (idx)
      `UFT_IDX_CTRL: begin
        rd_val[7:0] = sel_ch ? ctrl_r[15:8] : ctrl_r[7:0];
      end
      `UFT_IDX_RXDATA: begin
        rd_val[DW-1:0] = sel_ch ? rx_head_w[2*DW-1:DW] : rx_head_w[DW-1:0];
      end
      `UFT_IDX_STATUS: begin
        rd_val[`UFT_STAT_TXCNT +: 8] = ext8(tx_cnt_w[sel_ch*CW +: CW]);
        rd_val[`UFT_STAT_RXCNT +: 8] = ext8(rx_cnt_w[sel_ch*CW +: CW]);
        rd_val[`UFT_STAT_FLAGS +: 4] = {tx_full_w[sel_ch], tx_empty_w[sel_ch],
                                        rx_full_w[sel_ch], rx_empty_w[sel_ch]};
      end
      `UFT_IDX_ISTAT: begin
        rd_val[3:0] = sel_ch ? istat_r[7:4] : istat_r[3:0];
      end
      `UFT_IDX_IMASK: begin
        rd_val[3:0] = sel_ch ? imask_r[7:4] : imask_r[3:0];
      end
      default: begin
        rd_val = 32'h0000_0000;
      end
    endcase
    if (!hit) begin
      rd_val = 32'h0000_0000;
    end
  end

  // one wait state so read data and pready both leave flip-flops
  always @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else if (acc & ~pready_r) begin
      pready_r  <= 1'b1;
      pslverr_r <= ~hit;
      prdata_r  <= PWRITE_I ? 32'h0000_0000 : rd_val;
    end else begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end
  end

  always @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ctrl_r       <= {NCH{`UFT_CTRL_RST}}; // R9 R10
      istat_r      <= {NCH{`UFT_ISTAT_RST}};
      imask_r      <= {NCH{`UFT_IMASK_RST}};
      tx_empty_d_r <= {NCH{1'b1}};
      rx_hit_d_r   <= {NCH{1'b0}};
      irq_r        <= 1'b0;
    end else begin
      ctrl_r       <= ctrl_nxt;
      istat_r      <= istat_nxt;
      imask_r      <= imask_nxt;
      tx_empty_d_r <= tx_empty_w;
      rx_hit_d_r   <= rx_hit;
      irq_r        <= |(istat_r & imask_r);
    end
  end

  integer c;
  always @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      tx_req_n_r <= {NCH{1'b1}}; // R16
      rx_req_n_r <= {NCH{1'b1}}; // R16
      tx_avail_r <= {NCH{1'b0}};
      tx_data_r  <= {(NCH*DW){1'b0}};
    end else begin
      for (c = 0; c < NCH; c = c + 1) begin
        // a load while the fifo is empty is ignored and leaves the data as it was
        if (TX_LOAD_I[c] & ~tx_empty_w[c]) begin
          tx_data_r[c*DW +: DW] <= tx_head_w[c*DW +: DW];
        end
        tx_avail_r[c] <= ~tx_empty_w[c];
        if (mode1[c]) begin
          tx_req_n_r[c] <= tx_full_w[c]; // R5
          if (rx_empty_w[c]) begin
            rx_req_n_r[c] <= 1'b1; // R6
          end else if (rx_hit[c] | RX_TIMEOUT_I[c]) begin
            rx_req_n_r[c] <= 1'b0; // R6
          end
        end else begin
          tx_req_n_r[c] <= ~tx_empty_w[c]; // R1 R2
          rx_req_n_r[c] <= rx_empty_w[c]; // R3 R4
        end
      end
    end
  end

  assign PRDATA_O       = prdata_r;
  assign PREADY_O       = pready_r;
  assign PSLVERR_O      = pslverr_r;
  assign IRQ_O          = irq_r;
  assign TX_DATA_O      = tx_data_r;
  assign TX_AVAIL_O     = tx_avail_r;
  assign TX_REQUEST_N_O = tx_req_n_r;
  assign RX_REQUEST_N_O = rx_req_n_r;

endmodule

/* File: test/uft_props.sv */
`timescale 1ns/1ps
module uft_props (
  input wire logic        CORE_CLK_I,
  input wire logic        RST_N_I,
  input wire logic        PSEL_I,
  input wire logic        PENABLE_I,
  input wire logic        PWRITE_I,
  input wire logic [7:0]  PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic        PREADY_O,
  input wire logic        PSLVERR_O,
  input wire logic [1:0]  TX_AVAIL_O,
  input wire logic [1:0]  TX_REQUEST_N_O,
  input wire logic [1:0]  RX_PUSH_I,
  input wire logic [1:0]  RX_REQUEST_N_O
);
  logic       m1_r;
  logic [1:0] hist_r;
  wire        acc    = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I;
  wire        ctl_wr = acc && (PADDR_I == 8'h00);
  wire        tx_wr  = acc && (PADDR_I == 8'h04);
  wire        m0_set = !m1_r && (hist_r == 2'h0);
  wire        m1_set = m1_r && (hist_r == 2'h3);
  wire        tx_clr = ctl_wr && PWDATA_I[0] && PWDATA_I[2];
  // a receive request may only fall away after a data read or a control write
  wire        rx_gone = ctl_wr || (PSEL_I && PENABLE_I && PREADY_O && !PWRITE_I &&
                                   (PADDR_I == 8'h08));
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_N_I);
  // history resets to ones so the edges right after reset count as unsettled
  always @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      m1_r   <= 1'b0;
      hist_r <= 2'h3;
    end else begin
      if (ctl_wr)
        m1_r <= PWDATA_I[0] & PWDATA_I[3];
      hist_r <= {hist_r[0], m1_r};
    end
  end
  AST_RDY_PULSE: assert property (PREADY_O |=> !PREADY_O)
    else $error("pready held more than one cycle");
  AST_ERR_WITH_RDY: assert property (PSLVERR_O |-> PREADY_O)
    else $error("pslverr without pready");
  AST_WAIT_STATE: assert property ((PSEL_I && !PENABLE_I) |=> !PREADY_O ##1 PREADY_O)
    else $error("pready not in second access cycle");
  AST_UNALIGNED: assert property ((PREADY_O && PADDR_I[1:0] != 2'h0) |-> PSLVERR_O)
    else $error("unaligned access not refused");
  AST_M0_TXREQ: assert property (m0_set |-> TX_REQUEST_N_O[0] == TX_AVAIL_O[0])
    else $error("mode 0 tx request differs from fifo state");
  AST_M0_TXWR: assert property ((tx_wr && !m1_r) |-> ##[1:3] TX_REQUEST_N_O[0])
    else $error("tx request not released after write");
  AST_M1_TXREQ: assert property ((m1_set && TX_REQUEST_N_O[0]) |-> TX_AVAIL_O[0])
    else $error("mode 1 tx request high with empty fifo");
  AST_TX_CLEAR: assert property (tx_clr |-> ##[1:3] !TX_AVAIL_O[0])
    else $error("tx fifo not cleared");
  AST_M0_RXPUSH: assert property ((m0_set && RX_PUSH_I[0]) |-> ##2 !RX_REQUEST_N_O[0])
    else $error("mode 0 rx request not raised after push");
  AST_M0_RXGONE: assert property ((m0_set && $rose(RX_REQUEST_N_O[0])) |-> $past(rx_gone, 2))
    else $error("mode 0 rx request released without a read");
endmodule

bind uft_top uft_props uft_props_i (
  .CORE_CLK_I     (CORE_CLK_I),
  .RST_N_I        (RST_N_I),
  .PSEL_I         (PSEL_I),
  .PENABLE_I      (PENABLE_I),
  .PWRITE_I       (PWRITE_I),
  .PADDR_I        (PADDR_I),
  .PWDATA_I       (PWDATA_I),
  .PREADY_O       (PREADY_O),
  .PSLVERR_O      (PSLVERR_O),
  .TX_AVAIL_O     (TX_AVAIL_O),
  .TX_REQUEST_N_O (TX_REQUEST_N_O),
  .RX_PUSH_I      (RX_PUSH_I),
  .RX_REQUEST_N_O (RX_REQUEST_N_O)
);

/* File: test/uft_serial_model.sv */
`timescale 1ns/1ps
module uft_serial_model (
  input  wire        clk_i,
  output reg  [1:0]  tx_load_o,
  output reg  [1:0]  rx_push_o,
  output reg  [15:0] rx_data_o,
  output reg  [1:0]  rx_timeout_o
);
  initial begin
    tx_load_o    = 2'h0;
    rx_push_o    = 2'h0;
    rx_data_o    = 16'h0000;
    rx_timeout_o = 2'h0;
  end
  // idle data is inverted so sampling outside a push picks up junk
  task pulse(input [1:0] ld, input [1:0] ps, input [1:0] to, input [15:0] d);
    begin
      @(posedge clk_i);
      tx_load_o    <= ld;
      rx_push_o    <= ps;
      rx_timeout_o <= to;
      rx_data_o    <= d;
      @(posedge clk_i);
      tx_load_o    <= 2'h0;
      rx_push_o    <= 2'h0;
      rx_timeout_o <= 2'h0;
      rx_data_o    <= ~d;
    end
  endtask
endmodule

/* File: test/uft_top_tb_top.sv */
`timescale 1ns/1ps
module uft_top_tb_top;
  logic        clk;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] rdata;
  wire  [31:0] prdata;
  wire         pready;
  wire         pslverr;
  wire         irq;
  wire  [1:0]  tx_load;
  wire  [15:0] tx_data;
  wire  [1:0]  tx_avail;
  wire  [1:0]  rx_push;
  wire  [15:0] rx_data;
  wire  [1:0]  rx_to;
  wire  [1:0]  tx_req_n;
  wire  [1:0]  rx_req_n;
  integer      mismatches;
  integer      checks;
  integer      i;
  integer      k;
  integer      tx_holding_reg;
  logic [72:0] r;
  // address, write data, read-back, error flag
  logic [72:0] rows [0:6] = '{
    {8'h00, 32'h01, 32'h01, 1'b0}, {8'h00, 32'hc8, 32'h00, 1'b0},
    {8'h00, 32'hff, 32'hc9, 1'b0}, {8'h18, 32'h5a, 32'h00, 1'b1},
    {8'h02, 32'h5a, 32'h00, 1'b1}, {8'h40, 32'h5a, 32'h00, 1'b1},
    {8'h20, 32'h8b, 32'h89, 1'b0}};
  uft_top uft_top_i (
    .CORE_CLK_I     (clk),
    .RST_N_I        (rst_n),
    .PSEL_I         (psel),
    .PENABLE_I      (penable),
    .PWRITE_I       (pwrite),
    .PADDR_I        (paddr),
    .PWDATA_I       (pwdata),
    .PRDATA_O       (prdata),
    .PREADY_O       (pready),
    .PSLVERR_O      (pslverr),
    .IRQ_O          (irq),
    .TX_LOAD_I      (tx_load),
    .TX_DATA_O      (tx_data),
    .TX_AVAIL_O     (tx_avail),
    .RX_PUSH_I      (rx_push),
    .RX_DATA_I      (rx_data),
    .RX_TIMEOUT_I   (rx_to),
    .TX_REQUEST_N_O (tx_req_n),
    .RX_REQUEST_N_O (rx_req_n)
  );
  uft_serial_model uft_serial_model_i (
    .clk_i        (clk),
    .tx_load_o    (tx_load),
    .rx_push_o    (rx_push),
    .rx_data_o    (rx_data),
    .rx_timeout_o (rx_to)
  );
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    begin
      checks = checks + 1;
      if (g !== e) begin
        mismatches = mismatches + 1;
        $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task chkb(input string nm, input logic e, input logic g);
    chk(nm, {31'h0, e}, {31'h0, g});
  endtask
  task cyc(input integer n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask
  // the slave answer time is not assumed, only bounded
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    integer n;
    begin
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
        @(posedge clk);
        n = n + 1;
      end while (pready !== 1'b1 && n < 20);
      rdata = {prdata[31:1], prdata[0]};
      r[0]  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
        mismatches = mismatches + 1;
        end_of_test;
      end
    end
  endtask
  task rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    begin
      apb(1'b0, a, 32'h0);
      chk(nm, e, rdata);
    end
  endtask
  task push(input logic [15:0] d);
    uft_serial_model_i.pulse(2'h0, 2'h1, 2'h0, d);
  endtask
  initial begin
    mismatches = 0;
    checks     = 0;
    rst_n      = 1'b0;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = 8'h00;
    pwdata     = 32'h0;
    repeat (10) @(posedge clk);
    chk("req_rst", 32'hf, {28'h0, tx_req_n, rx_req_n});
    rst_n <= 1'b1;
    cyc(2);
    chk("req_idle", 32'h3, {28'h0, tx_req_n, rx_req_n});
    for (i = 0; i < 7; i = i + 1) begin
      apb(1'b1, rows[i][72:65], rows[i][64:33]);
      chk("wr_err", {31'h0, rows[i][0]}, {31'h0, r[0]});
      rdchk("rd_ctl", rows[i][72:65], rows[i][32:1]);
      chk("rd_err", {31'h0, rows[i][0]}, {31'h0, r[0]});
    end
    rst_n <= 1'b0;
    cyc(2);
    chk("req_mid_rst", 32'hf, {28'h0, tx_req_n, rx_req_n});
    @(posedge clk);
    rst_n <= 1'b1;
    rdchk("ctl_rst0", 8'h00, 32'h0);
    rdchk("ctl_rst1", 8'h20, 32'h0);
    for (k = 0; k < 4; k = k + 1) begin
      tx_holding_reg = (k == 0) ? 1 : (k == 1) ? 4 : (k == 2) ? 8 : 14;
      apb(1'b1, 8'h00, {24'h0, k[1:0], 6'h0b});
      apb(1'b1, 8'h10, 32'hf);
      for (i = 0; i < tx_holding_reg + 2; i = i + 1) begin
        if (i == tx_holding_reg - 1 || i == tx_holding_reg) begin
          cyc(2);
          chkb("rxreq_thr", i == tx_holding_reg - 1, rx_req_n[0]);
        end
        push({8'h00, 8'h30 + i[7:0]});
      end
      rdchk("stat_rx", 8'h0c, 32'h40000 + (tx_holding_reg + 2) * 256 + (tx_holding_reg == 14 ? 32'h20000 : 0));
      rdchk("istat_thr", 8'h10, 32'h2);
      cyc(2);
      for (i = 0; i < tx_holding_reg + 2; i = i + 1) begin
        chkb("rxreq_hold", 1'b0, rx_req_n[0]);
        rdchk("rxdata", 8'h08, 32'h30 + i);
      end
      cyc(2);
      chkb("rxreq_empty", 1'b1, rx_req_n[0]);
    end
    apb(1'b1, 8'h00, 32'h01);
    cyc(2);
    chkb("m0_txreq", 1'b0, tx_req_n[0]);
    apb(1'b1, 8'h04, 32'h55);
    cyc(2);
    chkb("m0_txwr", 1'b1, tx_req_n[0]);
    push(16'h0066);
    cyc(2);
    chkb("m0_rxreq", 1'b0, rx_req_n[0]);
    rdchk("m0_rxdata", 8'h08, 32'h66);
    cyc(2);
    chkb("m0_rxgone", 1'b1, rx_req_n[0]);
    apb(1'b1, 8'h00, 32'h00);
    cyc(2);
    chkb("off_txreq", 1'b0, tx_req_n[0]);
    apb(1'b1, 8'h04, 32'h77);
    cyc(2);
    chkb("off_txwr", 1'b1, tx_req_n[0]);
    uft_serial_model_i.pulse(2'h1, 2'h0, 2'h0, 16'h0);
    cyc(2);
    chk("off_load", 32'h077, {23'h0, tx_req_n[0], tx_data[7:0]});
    apb(1'b1, 8'h00, 32'h0d);
    apb(1'b1, 8'h14, 32'h1);
    apb(1'b1, 8'h10, 32'hf);
    for (i = 0; i < 17; i = i + 1)
      apb(1'b1, 8'h04, 32'ha0 + i);
    cyc(2);
    chkb("txreq_full", 1'b1, tx_req_n[0]);
    rdchk("stat_full", 8'h0c, 32'h00090010);
    for (i = 0; i < 16; i = i + 1) begin
      uft_serial_model_i.pulse(2'h1, 2'h0, 2'h0, 16'h0);
      cyc(2);
      chk("txdata", 32'ha0 + i, {24'h0, tx_data[7:0]});
      chkb("txreq_free", 1'b0, tx_req_n[0]);
    end
    cyc(1);
    chkb("irq_txempty", 1'b1, irq);
    apb(1'b1, 8'h14, 32'h0);
    cyc(2);
    chkb("irq_masked", 1'b0, irq);
    apb(1'b1, 8'h14, 32'h1);
    cyc(2);
    chkb("irq_unmask", 1'b1, irq);
    apb(1'b1, 8'h10, 32'h1);
    cyc(2);
    chkb("irq_clear", 1'b0, irq);
    for (i = 0; i < 3; i = i + 1)
      apb(1'b1, 8'h04, 32'h11);
    apb(1'b1, 8'h00, 32'h0d);
    cyc(2);
    chk("tx_clear", 32'h0af, {23'h0, tx_avail[0], tx_data[7:0]});
    rdchk("stat_txclr", 8'h0c, 32'h00050000);
    apb(1'b1, 8'h00, 32'h4b);
    push(16'h0001);
    cyc(2);
    chkb("rxreq_one", 1'b1, rx_req_n[0]);
    uft_serial_model_i.pulse(2'h0, 2'h0, 2'h1, 16'h0);
    cyc(2);
    chkb("rxreq_to", 1'b0, rx_req_n[0]);
    apb(1'b1, 8'h00, 32'h4b);
    cyc(2);
    chkb("rxreq_clr", 1'b1, rx_req_n[0]);
    rdchk("stat_rxclr", 8'h0c, 32'h00050000);
    // channel 1 runs on its own with fifos off while channel 0 sits in mode 1
    apb(1'b1, 8'h24, 32'h42);
    cyc(2);
    chk("ch1_txwr", 32'h2, {30'h0, tx_req_n});
    uft_serial_model_i.pulse(2'h2, 2'h2, 2'h0, 16'h5a00);
    cyc(2);
    chk("ch1_serial", 32'h142, {20'h0, tx_req_n, rx_req_n, tx_data[15:8]});
    rdchk("ch1_rxdata", 8'h28, 32'h5a);
    end_of_test;
  end
endmodule
